// ### rtl/sram_port_pkg.sv
`default_nettype none
package sram_port_pkg;
	localparam int ADDR_W            = 13;
	localparam int DATA_W            = 8;
	localparam int CLK_PERIOD_PS     = 25000;
	// Bus timing of the attached part, in ns; power-up recovery in ms
	localparam int ADDR_ACCESS_NS    = 100;
	localparam int OE_ACCESS_NS      = 50;
	localparam int STROBE_WIDTH_NS   = 80;
	localparam int DATA_SETUP_NS     = 50;
	localparam int RECOVERY_NS       = 10;
	localparam int DATA_HOLD_NS      = 5;
	localparam int POWER_UP_REC_MS   = 1;
	// Least times round up
	localparam int READ_CYC     = (ADDR_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
	localparam int STROBE_CYC   = (STROBE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SETUP_CYC    = (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RECOV_CYC    = (RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int HOLD_CYC     = (DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWER_UP_CYC = (POWER_UP_REC_MS * 1000000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W        = 16;
endpackage
`default_nettype wire

// ### rtl/sram_power_guard.sv
`default_nettype none
module sram_power_guard
	import sram_port_pkg::*;
#(
	parameter int REC_CYCLES = POWER_UP_CYC
) (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_power_good,
	output logic      o_ready
);
	typedef struct packed {
		logic             s1;
		logic             s2;
		logic [CNT_W-1:0] cnt;
		logic             ready;
	} guard_t;
	guard_t cur_ff;
	guard_t nxt_cur;

	always_comb begin
		nxt_cur    = cur_ff;
		nxt_cur.s1 = i_power_good;
		nxt_cur.s2 = cur_ff.s1;
		// Any drop restarts the wait; ready only after a full quiet interval
		if (!cur_ff.s2) begin
			nxt_cur.cnt   = '0;
			nxt_cur.ready = 1'b0;
		end else if (cur_ff.cnt < CNT_W'(REC_CYCLES)) begin
			nxt_cur.cnt   = cur_ff.cnt + 1'b1;
		end else begin
			nxt_cur.ready = 1'b1; // [R19] [R21]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst)
			cur_ff <= '0;
		else
			cur_ff <= nxt_cur;
	end

	assign o_ready = cur_ff.ready;

	AST_NOT_READY_LOW_POWER: assert property (@(posedge i_clk) disable iff (i_rst)
		!cur_ff.s2 |=> !o_ready) else $error("ready while power bad"); // [R21]
endmodule
`default_nettype wire

// ### rtl/sram_host_port.sv
`default_nettype none
// Function
// R1 - Read: select low, strobe high.
// R2 - Thirteen address bits select one of 8192 bytes.
// R3 - Read data sampled only after address access time.
// R4 - Sampling waits for the later of select and output-enable access.
// R5 - Device drives data only with select and output enable low.
// R6 - Data before address access time is indeterminate; never sampled.
// R7 - Address held fixed through a read; no sampling after changes.
// R8 - Write: select and strobe both low.
// R9 - Write starts at later falling edge of select or strobe.
// R10 - Write ends at the earlier rising edge; byte captured then.
// R11 - Address stays stable from write start until after its end.
// R12 - Select and strobe stay high for recovery time between cycles.
// R13 - Write data set up before end and held after end.
// R14 - Output enable kept high during writes.
// R15 - Strobe low floats device outputs after delay.
// R16 - Select and strobe falling together keep outputs floated.
// R17 - Power fail: device deselects, floats, ignores inputs.
// R18 - Power fail in a write may corrupt only that byte.
// R19 - Write protect lasts recovery time after power returns.
// R20 - Select kept high while supply rises through threshold.
// R21 - Power-up recovery with select high is at least 1 ms.
// R22 - Read data valid within 100 ns of address.
// R23 - Strobe held low at least 80 ns.
// R24 - Write data valid at least 50 ns before strobe rises.
// R25 - Power-good low forces deselect and no writes.
module sram_host_port
	import sram_port_pkg::*;
#(
	parameter int REC_CYCLES = POWER_UP_CYC
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_power_good,
	input  wire logic              i_req,
	input  wire logic              i_we,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	output logic                   o_busy,
	output logic                   o_done,
	output logic [DATA_W-1:0]      o_rdata,
	output logic [ADDR_W-1:0]      o_addr_pins,
	output logic                   o_sel_n,
	output logic                   o_oe_n,
	output logic                   o_we_n,
	output logic [DATA_W-1:0]      o_data_pins,
	output logic                   o_data_oe_n,
	input  wire logic [DATA_W-1:0] i_data_pins
);
	typedef enum logic [6:0] {
		ST_IDLE  = 7'b0000001,
		ST_READ  = 7'b0000010,
		ST_WRITE = 7'b0000100,
		ST_WHOLD = 7'b0001000,
		ST_RECOV = 7'b0010000,
		ST_SAMP  = 7'b0100000,
		ST_OFF   = 7'b1000000
	} state_t;

	typedef struct packed {
		state_t            st;
		logic [CNT_W-1:0]  cnt;
		logic [DATA_W-1:0] s1;
		logic [DATA_W-1:0] s2;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] rdata;
		logic              done;
		logic              sel_n;
		logic              oe_n;
		logic              we_n;
		logic              doe_n;
	} port_t;

	port_t cur_ff;
	port_t nxt_cur;
	logic  pwr_ready;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n);
	endfunction

	sram_power_guard #(
		.REC_CYCLES (REC_CYCLES)
	) u_guard (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_power_good (i_power_good),
		.o_ready      (pwr_ready)
	);

	// --------------------------------------------------------------
	// Sequencer
	// --------------------------------------------------------------
	always_comb begin
		nxt_cur      = cur_ff;
		nxt_cur.done = 1'b0;
		nxt_cur.s1   = i_data_pins;
		nxt_cur.s2   = cur_ff.s1;
		case (cur_ff.st)
			ST_IDLE: begin
				nxt_cur.cnt = '0;
				if (!pwr_ready) begin
					nxt_cur.st = ST_OFF; // [R20] [R25]
				end else if (i_req) begin
					nxt_cur.addr  = i_addr; // [R2]
					nxt_cur.wdata = i_wdata;
					nxt_cur.sel_n = 1'b0;
					if (i_we) begin
						// Data driven and strobe low with select: outputs never turn on [R16]
						nxt_cur.we_n  = 1'b0; // [R8] [R9]
						nxt_cur.oe_n  = 1'b1; // [R14]
						nxt_cur.doe_n = 1'b0;
						nxt_cur.st    = ST_WRITE;
					end else begin
						nxt_cur.oe_n = 1'b0; // [R1] [R5]
						nxt_cur.st   = ST_READ;
					end
				end
			end
			ST_READ: begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
				// Waits cover both access times plus two-stage sync latency [R3] [R4] [R6] [R22]
				if (cur_ff.cnt >= cyc(READ_CYC))
					nxt_cur.st = ST_SAMP;
			end
			ST_SAMP: begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
				if (cur_ff.cnt >= cyc(READ_CYC + 2)) begin
					nxt_cur.rdata = cur_ff.s2; // [R7]
					nxt_cur.done  = 1'b1;
					nxt_cur.sel_n = 1'b1;
					nxt_cur.oe_n  = 1'b1;
					nxt_cur.cnt   = '0;
					nxt_cur.st    = ST_RECOV;
				end
			end
			ST_WRITE: begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
				// Strobe width also covers the data setup [R13] [R23] [R24]
				if (cur_ff.cnt >= cyc(STROBE_CYC > SETUP_CYC ? STROBE_CYC - 1 : SETUP_CYC - 1)) begin
					nxt_cur.we_n  = 1'b1; // [R10]
					nxt_cur.cnt   = '0;
					nxt_cur.st    = ST_WHOLD;
				end
			end
			ST_WHOLD: begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
				if (cur_ff.cnt >= cyc(HOLD_CYC - 1)) begin
					nxt_cur.doe_n = 1'b1; // [R13]
					nxt_cur.sel_n = 1'b1;
					nxt_cur.done  = 1'b1;
					nxt_cur.cnt   = '0;
					nxt_cur.st    = ST_RECOV;
				end
			end
			ST_RECOV: begin
				nxt_cur.cnt = cur_ff.cnt + 1'b1;
				// Address stays put until recovery is over [R11] [R12]
				if (cur_ff.cnt >= cyc(RECOV_CYC - 1))
					nxt_cur.st = ST_IDLE;
			end
			ST_OFF: begin
				nxt_cur.sel_n = 1'b1; // [R17] [R18] [R25]
				nxt_cur.oe_n  = 1'b1;
				nxt_cur.we_n  = 1'b1;
				nxt_cur.doe_n = 1'b1;
				if (pwr_ready)
					nxt_cur.st = ST_IDLE; // [R19]
			end
			default: nxt_cur.st = ST_OFF;
		endcase
		// Power loss mid-cycle ends the access at once; only the current byte is at risk
		if (!pwr_ready && cur_ff.st != ST_IDLE && cur_ff.st != ST_OFF) begin
			nxt_cur.st    = ST_OFF; // [R18]
			nxt_cur.sel_n = 1'b1;
			nxt_cur.we_n  = 1'b1;
			nxt_cur.oe_n  = 1'b1;
			nxt_cur.doe_n = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cur_ff       <= '0;
			cur_ff.st    <= ST_OFF;
			cur_ff.sel_n <= 1'b1;
			cur_ff.oe_n  <= 1'b1;
			cur_ff.we_n  <= 1'b1;
			cur_ff.doe_n <= 1'b1;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	logic busy_ff;
	always_ff @(posedge i_clk) begin
		if (i_rst)
			busy_ff <= 1'b1;
		else
			busy_ff <= (nxt_cur.st != ST_IDLE) || !pwr_ready;
	end

	assign o_busy      = busy_ff;
	assign o_done      = cur_ff.done;
	assign o_rdata     = cur_ff.rdata;
	assign o_addr_pins = cur_ff.addr;
	assign o_sel_n     = cur_ff.sel_n;
	assign o_oe_n      = cur_ff.oe_n;
	assign o_we_n      = cur_ff.we_n;
	assign o_data_pins = cur_ff.wdata;
	assign o_data_oe_n = cur_ff.doe_n;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	AST_OE_HIGH_IN_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_we_n |-> o_oe_n) else $error("oe low during write"); // [R14]
	AST_STROBE_WIDTH: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_we_n) && pwr_ready |-> (!o_we_n)[*4]) else $error("strobe too short"); // [R23]
	AST_DATA_SETUP_HOLD: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_we_n) && !o_sel_n |-> !o_data_oe_n && $stable(o_data_pins)) else $error("write data hold"); // [R13]
	AST_ADDR_STABLE: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_sel_n && !$past(o_sel_n) |-> $stable(o_addr_pins)) else $error("address moved"); // [R11]
	AST_RECOVERY: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_sel_n) |=> o_sel_n) else $error("no recovery gap"); // [R12]
	AST_OFF_DESELECT: assert property (@(posedge i_clk) disable iff (i_rst)
		!pwr_ready |=> o_sel_n && o_we_n) else $error("selected during power fail"); // [R25]
	AST_READ_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(o_oe_n) |-> !o_done [*5]) else $error("read sampled early"); // [R22]
	AST_NO_DRIVE_IN_READ: assert property (@(posedge i_clk) disable iff (i_rst)
		!o_oe_n |-> o_data_oe_n) else $error("bus contention"); // [R5]
	COV_READ: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_oe_n) ##[1:20] o_done);
	COV_WRITE: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_we_n) ##[1:20] o_done);
	COV_PFAIL: cover property (@(posedge i_clk) disable iff (i_rst) !o_sel_n ##1 !pwr_ready);
endmodule
`default_nettype wire

// ### bench/sram_dev_model.sv
`default_nettype none
module sram_dev_model
	import sram_port_pkg::*;
#(
	parameter int REC_NS = 500
) (
	input  wire logic              i_power_good,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic              i_sel_n,
	input  wire logic              i_oe_n,
	input  wire logic              i_we_n,
	input  wire logic              i_host_oe_n,
	input  wire logic [DATA_W-1:0] i_dq,
	output logic      [DATA_W-1:0] o_dq,
	output int                     o_viol
);
	timeunit 1ns;
	timeprecision 100ps;
	// --
	// Storage and timing marks
	// --
	logic [DATA_W-1:0] mem [1<<ADDR_W];
	logic [ADDR_W-1:0] a_w;
	realtime           t_a = 0, t_s = 0, t_o = 0, t_ws = 0, t_we = -100, t_d = 0, n;
	bit                live = 1'b1, wr = 1'b0, drv;
	initial begin
		o_viol = 0;
		o_dq = 8'h00;
	end
	always @(i_addr) begin
		t_a = $realtime;
		if (wr) o_viol++;
	end
	always @(negedge i_sel_n) t_s = $realtime;
	always @(negedge i_oe_n) t_o = $realtime;
	always @(i_dq) t_d = $realtime;
	always @(negedge i_power_good) live = 1'b0;
	always @(posedge i_power_good) begin
		#(REC_NS);
		live = i_power_good;
	end
	// Unsettled or released pins toggle, so an early sample reads wrong
	always #2.5 begin
		n = $realtime;
		drv = live && !i_sel_n && !i_oe_n && i_we_n;
		if (drv && n >= t_a + ADDR_ACCESS_NS && n >= t_s + ADDR_ACCESS_NS && n >= t_o + OE_ACCESS_NS)
			o_dq = mem[i_addr];
		else
			o_dq = ~o_dq;
		if (drv && !i_host_oe_n) o_viol++;
	end
	always @(negedge i_we_n or negedge i_sel_n)
		if (!i_we_n && !i_sel_n && !wr) begin
			wr = 1'b1;
			t_ws = $realtime;
			a_w = i_addr;
			if (!live || t_ws - t_we < RECOVERY_NS) o_viol++;
		end
	always @(posedge i_we_n or posedge i_sel_n)
		if (wr) begin
			wr = 1'b0;
			t_we = $realtime;
			if (live) mem[a_w] = i_dq;
			if (t_we - t_ws < STROBE_WIDTH_NS || t_we - t_d < DATA_SETUP_NS) o_viol++;
		end
endmodule
`default_nettype wire

// ### bench/battery_backed_sram_port_bench.sv
`default_nettype none
module battery_backed_sram_port_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sram_port_pkg::*;
	// --
	// Clock, wiring, tasks
	// --
	logic              i_clk = 1'b0, i_rst = 1'b1, pg = 1'b1, req = 1'b0, we = 1'b0;
	logic [ADDR_W-1:0] addr = '0, pa;
	logic [DATA_W-1:0] wd = '0, rd, hd, md;
	wire  [DATA_W-1:0] dq;
	logic              busy, done, sel_n, oe_n, we_n, hoe_n;
	int                viol, bad_count = 0, total_checks = 0;
	always #12.5 i_clk = ~i_clk;
	assign dq = hoe_n ? md : hd;
	sram_host_port #(.REC_CYCLES(20)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_power_good(pg), .i_req(req),
		.i_we(we), .i_addr(addr), .i_wdata(wd), .o_busy(busy), .o_done(done), .o_rdata(rd),
		.o_addr_pins(pa), .o_sel_n(sel_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_data_pins(hd),
		.o_data_oe_n(hoe_n), .i_data_pins(dq));
	sram_dev_model #(.REC_NS(500)) dev (.i_power_good(pg), .i_addr(pa), .i_sel_n(sel_n), .i_oe_n(oe_n),
		.i_we_n(we_n), .i_host_oe_n(hoe_n), .i_dq(dq), .o_dq(md), .o_viol(viol));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_idle;
		for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge i_clk);
		if (busy !== 1'b0) begin
			chk(busy, 1'b0);
			end_sim();
		end
	endtask
	// Request is held one edge only: busy was low, so that edge takes it
	task automatic op(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] r);
		logic ok;
		wait_idle();
		req = 1'b1;
		we = w;
		addr = a;
		wd = d;
		@(negedge i_clk);
		req = 1'b0;
		ok = 1'b0;
		for (int i = 0; i < 30 && !ok; i++) begin
			@(negedge i_clk);
			ok = done === 1'b1;
			r = rd;
		end
		chk(ok, 1'b1);
		if (!ok)
			end_sim();
	endtask
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] r;
		op(1'b1, a, d, r);
	endtask
	task automatic rdchk(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] r;
		op(1'b0, a, 8'h00, r);
		chk(r, e);
	endtask
	task automatic t_reset;
		repeat (5) @(negedge i_clk);
		chk({busy, sel_n, we_n, oe_n, hoe_n}, 5'h1f);
		i_rst = 1'b0;
		repeat (3) @(negedge i_clk);
		chk(busy, 1'b1);
		wait_idle();
		$display("test reset done");
	endtask
	task automatic t_rw;
		logic [12:0] al [4] = '{13'h0000, 13'h1fff, 13'h0aaa, 13'h1555};
		for (int i = 0; i < 4; i++) wr(al[i], 8'h5a ^ 8'(i));
		for (int i = 3; i >= 0; i--) rdchk(al[i], 8'h5a ^ 8'(i));
		$display("test read write done");
	endtask
	task automatic t_pfail;
		wait_idle();
		req = 1'b1;
		we = 1'b1;
		addr = 13'h0aaa;
		wd = 8'hc3;
		@(negedge i_clk);
		req = 1'b0;
		pg = 1'b0;
		repeat (6) begin
			@(negedge i_clk);
			chk(done, 1'b0);
		end
		chk({busy, sel_n, we_n, hoe_n}, 4'hf);
		pg = 1'b1;
		repeat (10) @(negedge i_clk);
		chk(busy, 1'b1);
		rdchk(13'h1fff, 8'h5b);
		wr(13'h0aaa, 8'h3c);
		rdchk(13'h0aaa, 8'h3c);
		$display("test power fail done");
	endtask
	initial begin
		t_reset();
		t_rw();
		t_pfail();
		chk(viol, 0);
		end_sim();
	end
endmodule
`default_nettype wire
